// ### rtl/bscce_params.svh
// constants for the bit-skip, call-via-accumulator and clear-accumulator execution block
`ifndef BSCCE_PARAMS_SVH
`define BSCCE_PARAMS_SVH
`define BSCCE_PC_W        10
`define BSCCE_ADDR_W      6
`define BSCCE_OPC_W       3
`define BSCCE_SP_W        3
`define BSCCE_PC_RST      10'h000
`define BSCCE_ACC_RST     8'h00
`define BSCCE_Z_RST       1'b0
`define BSCCE_Z_SET       1'b1
`define BSCCE_SP_RST      3'h0
`define BSCCE_ZERO_BYTE   8'h00
`define BSCCE_PC_STEP     10'h001
`define BSCCE_SP_STEP     3'h1
`define BSCCE_OP_NOP      3'h0
`define BSCCE_OP_TSKC     3'h1
`define BSCCE_OP_TSKS     3'h2
`define BSCCE_OP_CALL_VIA_ACCUMULATOR    3'h3
`define BSCCE_OP_CLEAR_ACCUMULATOR     3'h4
`define BSCCE_TBH_LO      1
`define BSCCE_BIT_CLEAR   1'b0
`define BSCCE_BIT_SET     1'b1
`endif

// ### rtl/bscce_pkg.sv
// types for the bit-skip, call and clear execution block
`include "bscce_params.svh"
package bscce_pkg;
	typedef struct packed {
		logic [`BSCCE_OPC_W-1:0]  opcode;
		logic [`BSCCE_ADDR_W-1:0] reg_addr;
		logic [2:0]               bit_sel;
	} bscce_instr_t;
	typedef struct packed {
		logic                   push;
		logic [`BSCCE_PC_W-1:0] data;
	} bscce_push_t;
	typedef enum logic [2:0] {
		BSCCE_EXEC  = 3'h1,
		BSCCE_SKIP  = 3'h2,
		BSCCE_CALL2 = 3'h4
	} bscce_state_t;
endpackage : bscce_pkg

// ### rtl/bscce_bit_test.sv
// bit-test decision for the two skip instructions
`timescale 1ns/10ps
`default_nettype none
`include "bscce_params.svh"
module bscce_bit_test (
	// operands
	input  wire logic [7:0] reg_data,
	input  wire logic [2:0] bit_sel,
	input  wire logic       want_set,
	// decision
	output logic            skip
);
	wire logic picked;
	assign picked = reg_data[bit_sel];
	assign skip = want_set ? (picked == `BSCCE_BIT_SET) : (picked == `BSCCE_BIT_CLEAR);
endmodule : bscce_bit_test
`default_nettype wire

// ### rtl/bscce_core.sv
// execution of bit-skip, call-via-accumulator and clear-accumulator
`timescale 1ns/10ps
`default_nettype none
`include "bscce_params.svh"
module bscce_core (
	// clock and reset
	input  wire logic                        clock,
	input  wire logic                        rst,
	// instruction from fetch stage
	input  wire logic                        instr_valid,
	input  wire bscce_pkg::bscce_instr_t     instr,
	// register file read port
	output logic [`BSCCE_ADDR_W-1:0]         reg_raddr,
	input  wire logic [7:0]                  reg_rdata,
	input  wire logic [7:0]                  table_high_pointer,
	// accumulator result from the rest of the core
	input  wire logic                        acc_we,
	input  wire logic [7:0]                  acc_wdata,
	// architectural state
	output logic [`BSCCE_PC_W-1:0]           pc,
	output logic [7:0]                       accumulator,
	output logic                             zero_flag,
	output logic [`BSCCE_SP_W-1:0]           stack_ptr,
	// stack push and pipeline status
	output bscce_pkg::bscce_push_t           stack_push,
	output logic                             flush,
	output logic                             busy
);
	// state machine and architectural registers
	bscce_pkg::bscce_state_t     state_q;
	bscce_pkg::bscce_state_t     state_d;
	logic [`BSCCE_PC_W-1:0]      pc_q;
	logic [`BSCCE_PC_W-1:0]      pc_d;
	logic [7:0]                  acc_q;
	logic [7:0]                  acc_d;
	logic                        z_q;
	logic                        z_d;
	logic [`BSCCE_SP_W-1:0]      sp_q;
	logic [`BSCCE_SP_W-1:0]      sp_d;
	bscce_pkg::bscce_push_t      push_q;
	bscce_pkg::bscce_push_t      push_d;

	// pc of the following word: fall-through, skip slot and return address
	function automatic logic [`BSCCE_PC_W-1:0] next_pc(
		input logic [`BSCCE_PC_W-1:0] p
	);
		next_pc = p + `BSCCE_PC_STEP;
	endfunction : next_pc

	function automatic logic op_is(
		input logic [`BSCCE_OPC_W-1:0] opc,
		input logic [`BSCCE_OPC_W-1:0] code
	);
		op_is = (opc == code);
	endfunction : op_is

	// call target: low bits of the table-high pointer above the accumulator
	function automatic logic [`BSCCE_PC_W-1:0] call_target(
		input logic [7:0] high,
		input logic [7:0] low
	);
		call_target = {high[`BSCCE_TBH_LO:0], low};
	endfunction : call_target

	function automatic logic [`BSCCE_SP_W-1:0] next_sp(
		input logic [`BSCCE_SP_W-1:0] s
	);
		next_sp = s + `BSCCE_SP_STEP;
	endfunction : next_sp

	// instruction decode
	wire logic                   in_exec;
	wire logic                   in_skip;
	wire logic                   in_call2;
	wire logic                   is_tskc;
	wire logic                   is_tsks;
	wire logic                   is_call;
	wire logic                   is_clear_accumulator;
	wire logic                   is_test;
	wire logic                   bit_skip;
	wire logic                   take_skip;
	wire logic                   acc_load;
	wire logic [`BSCCE_PC_W-1:0] pc_seq;
	wire logic [`BSCCE_PC_W-1:0] pc_call;
	wire logic [`BSCCE_SP_W-1:0] sp_inc;

	// a word is taken only in the execute state
	assign in_exec   = (state_q == bscce_pkg::BSCCE_EXEC) && instr_valid;
	assign in_skip   = (state_q == bscce_pkg::BSCCE_SKIP);
	assign in_call2  = (state_q == bscce_pkg::BSCCE_CALL2);
	assign is_tskc   = in_exec && op_is(instr.opcode, `BSCCE_OP_TSKC);
	assign is_tsks   = in_exec && op_is(instr.opcode, `BSCCE_OP_TSKS);
	assign is_call   = in_exec && op_is(instr.opcode, `BSCCE_OP_CALL_VIA_ACCUMULATOR);
	assign is_clear_accumulator   = in_exec && op_is(instr.opcode, `BSCCE_OP_CLEAR_ACCUMULATOR);
	assign is_test   = is_tskc || is_tsks;
	assign reg_raddr = instr.reg_addr;

	// bit picked from the addressed register decides the skip
	bscce_bit_test u_bit_test (
		.reg_data (reg_rdata),
		.bit_sel  (instr.bit_sel),
		.want_set (is_tsks),
		.skip     (bit_skip)
	);

	assign take_skip = is_test && bit_skip;
	// a result from elsewhere must not land in the skipped slot or the call,
	// and bit tests, call and clear own the accumulator in their own cycle
	assign acc_load  = acc_we && (state_q == bscce_pkg::BSCCE_EXEC)
		&& !is_test && !is_call && !is_clear_accumulator;

	// candidate program counter and stack pointer values
	assign pc_seq    = next_pc(pc_q);
	assign pc_call   = call_target(table_high_pointer, acc_q);
	assign sp_inc    = next_sp(sp_q);

	// next values; the case follows the state register
	always_comb begin
		state_d = state_q;
		pc_d    = pc_q;
		acc_d   = acc_q;
		z_d     = z_q;
		sp_d    = sp_q;
		push_d  = '0;
		case (state_q)
			bscce_pkg::BSCCE_EXEC: begin
				if (acc_load) begin
					acc_d = acc_wdata;
				end
				if (instr_valid) begin
					pc_d = pc_seq;
					if (take_skip) begin
						state_d = bscce_pkg::BSCCE_SKIP;
					end else if (is_call) begin
						push_d.push = 1'b1;
						push_d.data = pc_seq;
						sp_d        = sp_inc;
						pc_d        = pc_call;
						state_d     = bscce_pkg::BSCCE_CALL2;
					end else if (is_clear_accumulator) begin
						acc_d = `BSCCE_ZERO_BYTE;
						z_d   = `BSCCE_Z_SET;
					end
				end
			end
			bscce_pkg::BSCCE_SKIP: begin
				// discarded word: pc moves on, nothing else changes
				pc_d    = pc_seq;
				state_d = bscce_pkg::BSCCE_EXEC;
			end
			bscce_pkg::BSCCE_CALL2: begin
				// second call cycle: the stack write settles, nothing else moves
				state_d = bscce_pkg::BSCCE_EXEC;
			end
			default: begin
				state_d = bscce_pkg::BSCCE_EXEC;
			end
		endcase
	end

	// one short register process per state element, synchronous reset
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= bscce_pkg::BSCCE_EXEC;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pc_q <= `BSCCE_PC_RST;
		end else begin
			pc_q <= pc_d;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			acc_q <= `BSCCE_ACC_RST;
		end else begin
			acc_q <= acc_d;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			z_q <= `BSCCE_Z_RST;
		end else begin
			z_q <= z_d;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sp_q <= `BSCCE_SP_RST;
		end else begin
			sp_q <= sp_d;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			push_q <= '0;
		end else begin
			push_q <= push_d;
		end
	end

	// outputs come straight from the registers, except flush and busy, which are decoded from the state register
	assign pc          = pc_q;
	assign accumulator = acc_q;
	assign zero_flag   = z_q;
	assign stack_ptr   = sp_q;
	assign stack_push  = push_q;
	assign flush       = in_skip;
	assign busy        = in_skip || in_call2;
endmodule : bscce_core
`default_nettype wire

// ### verif/bscce_monitor.sv
// assertion checker for the execution block
`timescale 1ns/10ps
`default_nettype none
module bscce_monitor (
	// clock and reset
	input wire logic                    clock,
	input wire logic                    rst,
	// instruction side
	input wire logic                    instr_valid,
	input wire bscce_pkg::bscce_instr_t instr,
	input wire logic [7:0]              reg_rdata,
	input wire logic [7:0]              table_high_pointer,
	// state and status
	input wire logic                    busy,
	input wire logic                    flush,
	input wire logic                    zero_flag,
	input wire logic [7:0]              accumulator,
	input wire logic [9:0]              pc,
	input wire logic [2:0]              stack_ptr,
	input wire bscce_pkg::bscce_push_t  stack_push
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire logic       t   = instr_valid && !busy;
	wire logic [2:0] o   = instr.opcode;
	wire logic       b   = reg_rdata[instr.bit_sel];
	wire logic       tst = t && (o == 3'h1 || o == 3'h2);
	wire logic       sk  = tst && (b == (o == 3'h2));
	wire logic [9:0] tgt = {table_high_pointer[1:0], accumulator};
	a_skip_clear: assert property (
		t && o == 3'h1 && !b |=> flush && busy) else $error("no skip on clear");
	a_skip_set: assert property (
		t && o == 3'h2 && b |=> flush && busy) else $error("no skip on set");
	a_no_skip: assert property (
		tst && !sk |=> !flush && !busy) else $error("skip without cause");
	a_slot_quiet: assert property (
		flush |=> pc == $past(pc) + 10'h1 && $stable(stack_ptr) && !stack_push.push
		&& $stable(accumulator) && $stable(zero_flag))
		else $error("skipped slot not quiet");
	a_test_flags: assert property (
		tst |=> $stable(zero_flag) && $stable(accumulator)) else $error("test changed flags");
	a_call_push: assert property (
		t && o == 3'h3 |=> stack_push == {1'b1, $past(pc) + 10'h1}
		&& stack_ptr == $past(stack_ptr) + 3'h1) else $error("bad call push");
	a_call_two: assert property (
		t && o == 3'h3 |=> busy ##1 !busy && !stack_push.push) else $error("call not 2 cycles");
	a_call_target: assert property (
		t && o == 3'h3 |=> pc == $past(tgt)) else $error("bad call target");
	a_clear_acc: assert property (
		t && o == 3'h4 |=> accumulator == 8'h00 && zero_flag) else $error("bad clear");
	cover property (sk);
	cover property (t && o == 3'h3);
	cover property (t && o == 3'h4);
endmodule : bscce_monitor
bind bscce_core bscce_monitor i_bscce_monitor (.clock, .rst, .instr_valid, .busy, .flush,
	.zero_flag, .instr, .reg_rdata, .table_high_pointer, .accumulator, .pc, .stack_ptr,
	.stack_push);
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the execution block
`timescale 1ns/10ps
`default_nettype none
`include "bscce_params.svh"
module tb;
	logic                    clock = 0, rst = 1, instr_valid = 0, zero_flag, flush, busy;
	logic                    acc_we = 0;
	bscce_pkg::bscce_instr_t instr = '0;
	logic [7:0]              reg_rdata = 8'h5A, tbh = 8'hFE, acc, acc_wdata = 8'h00;
	logic [9:0]              pc, ep = 10'h000;
	logic [5:0]              raddr;
	logic [2:0]              sp;
	bscce_pkg::bscce_push_t  push;
	int                      bad_count = 0, total_checks = 0, cyc = 0;
	bscce_core i_bscce_core (.clock, .rst, .instr_valid, .instr, .reg_raddr(raddr), .reg_rdata,
		.table_high_pointer(tbh), .acc_we, .acc_wdata, .pc, .accumulator(acc), .zero_flag,
		.stack_ptr(sp), .stack_push(push), .flush, .busy);
	initial forever #20 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			bad_count++;
			stop_test();
		end
	end
	task chk(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task stop_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task ex(input logic [2:0] o, input logic [5:0] a, input logic [2:0] b, input logic w);
		@(posedge clock);
		instr_valid <= 1'b1;
		instr <= '{o, a, b};
		@(posedge clock);
		instr_valid <= 1'b0;
		acc_we <= w;
		acc_wdata <= 8'h3C;
		#1;
	endtask : ex
	task t_skip();
		logic       e;
		logic [5:0] a;
		for (int i = 0; i < 16; i++) begin
			e = (reg_rdata[i[2:0]] == i[3]);
			a = {i[3:0], i[1:0]};
			ex(i[3] ? `BSCCE_OP_TSKS : `BSCCE_OP_TSKC, a, i[2:0], e);
			chk(flush, e);
			chk(raddr, a);
			chk({zero_flag, acc}, 9'h000);
			@(posedge clock);
			acc_we <= 1'b0;
			#1;
			ep = ep + (e ? 10'h2 : 10'h1);
			chk({zero_flag, acc, sp, push.push, pc}, {13'h0000, ep});
		end
		$display("skip test done");
	endtask : t_skip
	task t_call();
		@(posedge clock);
		acc_we <= 1'b1;
		acc_wdata <= 8'hC5;
		@(posedge clock);
		acc_we <= 1'b0;
		instr_valid <= 1'b1;
		instr <= '{`BSCCE_OP_CALL_VIA_ACCUMULATOR, 6'h00, 3'h0};
		#1;
		chk(acc, 8'hC5);
		@(posedge clock);
		instr <= '{`BSCCE_OP_CLEAR_ACCUMULATOR, 6'h00, 3'h0};
		#1;
		chk({pc, push}, {tbh[1:0], 8'hC5, 1'b1, ep + 10'h1});
		chk(sp, 3'h1);
		ep = {tbh[1:0], 8'hC5};
		@(posedge clock);
		instr_valid <= 1'b0;
		#1;
		chk({zero_flag, busy, push.push, acc, pc}, {3'h0, 8'hC5, ep});
		$display("call test done");
	endtask : t_call
	task t_clear();
		ex(`BSCCE_OP_CLEAR_ACCUMULATOR, 6'h00, 3'h0, 1'b0);
		ep = ep + 10'h1;
		chk({zero_flag, acc, pc}, {1'b1, 8'h00, ep});
		$display("clear test done");
	endtask : t_clear
	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		t_skip();
		t_call();
		t_clear();
		stop_test();
	end
endmodule : tb
`default_nettype wire
